// File: src/chacs_adapter.sv
`timescale 1ns/1ps
`include "chacs_map.svh"
module chacs_adapter #(
    parameter int WC_W = 14,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Controller command port
    input  wire chacs_pkg::chacs_io_control_command_t ioCmd,
    output logic [15:0]      senseWord_ff,
    output logic             senseValid_ff,
    output logic             ctlIrq_ff,
    output logic             addrCheckIrq_ff,
    // Controller cycle-steal port
    output logic             cycle_steal_request_latch_ff,
    output logic             csDirToCtl_ff,
    output logic [15:0]      csWrData_ff,
    input  wire logic        csDone,
    input  wire logic [15:0] csRdData,
    input  wire logic        csParityErr,
    input  wire logic        csProtectErr,
    input  wire logic        csChain,
    // Mainframe channel
    input  wire logic        hostCmdValid,
    input  wire logic [7:0]  hostCmd,
    input  wire logic        hostNoop,
    input  wire logic        hostStop,
    input  wire logic        hostDisconnect,
    input  wire logic        hostSelReset,
    input  wire logic        hostMasterReset,
    input  wire logic        hostStatusAccept,
    input  wire logic        hostBusOutParityErr,
    input  wire logic        hostWrValid,
    input  wire logic [15:0] hostWrData,
    output logic             hostWrReady_ff,
    output logic             hostRdValid_ff,
    output logic [15:0]      hostRdData_ff,
    input  wire logic        hostRdReady,
    output logic [7:0]       hostStatus_ff
);
    logic [15:0] ctlBuf_ff;
    logic [WC_W-1:0] wordCnt_ff;
    logic [1:0]  scan_ff;
    logic [7:0]  hostCmdByte_ff;
    logic        hostHeld_ff;
    logic        hostIsCtrl_ff;
    logic        ctlHeld_ff;
    logic        ctlIsRead_ff;
    logic        firstCycle_ff;
    logic        ctrlDePending_ff;
    logic [7:0]  flags_ff;
    chacs_pkg::chacs_state_t state_ff;
    chacs_pkg::chacs_dir_t   dir_ff;

    // Double-flopped mainframe stop, disconnect, reset, accept and parity pins; controller inputs share our clock
    logic [5:0] hSync1_ff;
    logic [5:0] hSync2_ff;
    always_ff @(posedge core_clk)
    begin
        hSync1_ff <= {hostStop, hostDisconnect, hostSelReset,
                      hostMasterReset, hostStatusAccept, hostBusOutParityErr};
        hSync2_ff <= hSync1_ff;
    end
    logic hStop, hDisc, hSelRst, hMstRst, hAccept, hBoPar;
    assign {hStop, hDisc, hSelRst, hMstRst, hAccept, hBoPar} = hSync2_ff;

    function automatic logic hostIsRead(input logic [7:0] c);
        return (c[1:0] == `CHACS_HC_READ) || (c[3:0] == `CHACS_HC_RDBK);
    endfunction

    // Command decode
    logic [2:0] fn;
    logic cmdOk, isInitRd, isInitWr, isInit, isSense, isCtlFn, badFn;
    logic conflict, overlap, rejectInit, acceptInit, matchHost, clrSense;
    assign fn       = ioCmd.word.func;
    assign cmdOk    = ioCmd.valid && ioCmd.parityOk;
    assign isInitRd = cmdOk && fn == `CHACS_FN_INIT_RD;
    assign isInitWr = cmdOk && fn == `CHACS_FN_INIT_WR;
    assign isInit   = isInitRd || isInitWr;
    assign isSense  = cmdOk && fn == `CHACS_FN_SENSE_DEV;
    assign isCtlFn  = cmdOk && fn == `CHACS_FN_CONTROL;
    assign badFn    = cmdOk && !(isInit || isSense || isCtlFn || fn == `CHACS_FN_SENSE_INT);
    assign overlap  = ctlHeld_ff || flags_ff[`CHACS_SW_XEND];
    assign conflict = hostHeld_ff && (hostIsCtrl_ff ||
                      (isInitRd ? hostIsRead(hostCmdByte_ff) : !hostIsRead(hostCmdByte_ff)));
    assign rejectInit = isInit && (overlap || conflict);
    assign acceptInit = isInit && !rejectInit;
    assign matchHost  = acceptInit && hostHeld_ff;
    assign clrSense   = isSense && ioCmd.word.modifier[`CHACS_CLR_BIT];

    logic fullReset;
    assign fullReset = rst || isCtlFn || hSelRst || hMstRst;

    // Data path FIFO; back-pressure stalls the far-side pins and cycle steals
    logic fInValid, fInReady, fOutValid, fOutReady;
    logic [15:0] fInData, fOutData;
    logic toCtl;
    assign toCtl     = dir_ff == chacs_pkg::CHACS_DIR_TOCTL;
    assign fInValid  = state_ff == chacs_pkg::CHACS_XFER &&
                       (toCtl ? hostWrValid && hostWrReady_ff : csDone && !csDirToCtl_ff && !firstCycle_ff);
    assign fInData   = toCtl ? hostWrData : csRdData;
    assign fOutReady = toCtl ? (csDone && csDirToCtl_ff) : (!hostRdValid_ff || hostRdReady);
    chacs_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) uFifo (
        .core_clk (core_clk),
        .rst      (rst),
        .flush    (fullReset || state_ff == chacs_pkg::CHACS_IDLE),
        .inValid  (fInValid),
        .inReady  (fInReady),
        .inData   (fInData),
        .outValid (fOutValid),
        .outReady (fOutReady),
        .outData  (fOutData)
    );

    // Word counter and end detection
    logic wordDone, wcZeroNext, parityHit, protectHit, hostHalt, endNow;
    assign wordDone   = state_ff == chacs_pkg::CHACS_XFER && csDone && !firstCycle_ff;
    assign wcZeroNext = wordDone && wordCnt_ff == WC_W'(1);
    assign parityHit  = (csDone && csParityErr) || (state_ff == chacs_pkg::CHACS_XFER && hBoPar);
    assign protectHit = wordDone && csProtectErr && toCtl;
    assign hostHalt   = state_ff == chacs_pkg::CHACS_XFER && (hStop || hDisc);
    assign endNow     = state_ff == chacs_pkg::CHACS_XFER &&
                        ((wcZeroNext && !csChain) || hostHalt || (parityHit && !firstCycle_ff) || protectHit);
    logic firstParityReset;
    assign firstParityReset = firstCycle_ff && csDone && csParityErr && !hostHeld_ff;

    always_ff @(posedge core_clk)
    begin
        if (fullReset || firstParityReset)
        begin
            state_ff <= chacs_pkg::CHACS_IDLE;
            dir_ff   <= chacs_pkg::CHACS_DIR_NONE;
            ctlHeld_ff <= 1'b0;
            ctlIsRead_ff <= 1'b0;
            firstCycle_ff <= 1'b0;
            wordCnt_ff <= '0;
            scan_ff <= '0;
            ctlBuf_ff <= '0;
        end
        else
        begin
            if (acceptInit)
            begin
                ctlBuf_ff <= ioCmd.word;
                ctlHeld_ff <= 1'b1;
                ctlIsRead_ff <= isInitRd;
                firstCycle_ff <= 1'b1;
                state_ff <= matchHost ? chacs_pkg::CHACS_XFER : chacs_pkg::CHACS_WAITING;
                dir_ff <= isInitRd ? chacs_pkg::CHACS_DIR_TOCTL : chacs_pkg::CHACS_DIR_TOHOST;
            end
            else if (state_ff == chacs_pkg::CHACS_WAITING && hostCmdValid && !hostIsCtrl_ff &&
                     (ctlIsRead_ff ? !hostIsRead(hostCmd) : hostIsRead(hostCmd)))
                state_ff <= chacs_pkg::CHACS_XFER;
            else if (endNow)
            begin
                state_ff <= chacs_pkg::CHACS_ENDING;
                ctlHeld_ff <= 1'b0;
            end
            else if (state_ff == chacs_pkg::CHACS_ENDING && hAccept)
            begin
                state_ff <= chacs_pkg::CHACS_IDLE;
                dir_ff <= chacs_pkg::CHACS_DIR_NONE;
            end
            // First steal loads the count and scan bits
            if (state_ff == chacs_pkg::CHACS_XFER && firstCycle_ff && csDone && !csParityErr)
            begin
                wordCnt_ff <= csRdData[WC_W-1:0];
                scan_ff <= csRdData[15:14];
                firstCycle_ff <= 1'b0;
            end
            else if (wordDone)
                wordCnt_ff <= wordCnt_ff - 1'b1;
        end
    end

    // Cycle-steal request latch; cleared by every reset form
    always_ff @(posedge core_clk)
    begin
        if (fullReset || firstParityReset || endNow)
        begin
            cycle_steal_request_latch_ff <= 1'b0;
            csDirToCtl_ff <= 1'b0;
            csWrData_ff <= '0;
        end
        else if (state_ff == chacs_pkg::CHACS_XFER && !cycle_steal_request_latch_ff)
        begin
            if (firstCycle_ff)
            begin
                cycle_steal_request_latch_ff <= 1'b1;
                csDirToCtl_ff <= 1'b0;
            end
            else if (toCtl && fOutValid)
            begin
                cycle_steal_request_latch_ff <= 1'b1;
                csDirToCtl_ff <= 1'b1;
                csWrData_ff <= fOutData;
            end
            else if (!toCtl && fInReady)
            begin
                cycle_steal_request_latch_ff <= 1'b1;
                csDirToCtl_ff <= 1'b0;
            end
        end
        else if (csDone)
            cycle_steal_request_latch_ff <= 1'b0;
    end

    // Mainframe data pins
    always_ff @(posedge core_clk)
    begin
        if (fullReset)
        begin
            hostWrReady_ff <= 1'b0;
            hostRdValid_ff <= 1'b0;
            hostRdData_ff <= '0;
        end
        else
        begin
            hostWrReady_ff <= state_ff == chacs_pkg::CHACS_XFER && toCtl && fInReady && !fInValid;
            if (!toCtl && fOutValid && fOutReady)
            begin
                hostRdValid_ff <= 1'b1;
                hostRdData_ff <= fOutData;
            end
            else if (hostRdReady)
                hostRdValid_ff <= 1'b0;
        end
    end

    // Held mainframe command
    always_ff @(posedge core_clk)
    begin
        if (fullReset)
        begin
            hostHeld_ff <= 1'b0;
            hostIsCtrl_ff <= 1'b0;
            hostCmdByte_ff <= '0;
            ctrlDePending_ff <= 1'b0;
        end
        else if (hostCmdValid && !hostHeld_ff)
        begin
            hostHeld_ff <= 1'b1;
            hostCmdByte_ff <= hostCmd;
            hostIsCtrl_ff <= hostCmd[1:0] == `CHACS_HC_CTRL;
        end
        else if ((hostIsCtrl_ff && clrSense) || (!hostIsCtrl_ff && endNow))
        begin
            hostHeld_ff <= 1'b0;
            ctrlDePending_ff <= hostIsCtrl_ff;
        end
        else if (hAccept)
            ctrlDePending_ff <= 1'b0;
    end

    // Sticky status word flags; a new event wins over a sense clear
    logic [7:0] setF;
    always_comb
    begin
        setF = '0;
        setF[`CHACS_SW_REJECT]  = badFn || rejectInit;
        setF[`CHACS_SW_HALT]    = hostHalt;
        setF[`CHACS_SW_DCHECK]  = parityHit;
        setF[`CHACS_SW_PROTECT] = protectHit;
        setF[`CHACS_SW_XEND]    = endNow;
        setF[`CHACS_SW_EOT]     = wcZeroNext && scan_ff != 2'h0;
    end
    always_ff @(posedge core_clk)
    begin
        if (fullReset)
            flags_ff <= '0;
        else
            flags_ff <= setF | (clrSense ? 8'h00 : flags_ff);
    end

    logic hostIrq;
    assign hostIrq = hostCmdValid && !hostHeld_ff && !hostNoop &&
                     (hostCmd[1:0] == `CHACS_HC_CTRL || (!hostCmd[2] && !ctlHeld_ff));

    // Controller-facing outputs
    logic [15:0] statusWord;
    always_comb
    begin
        statusWord = {{<<{flags_ff}}, 8'h00};
        statusWord[15-`CHACS_SW_CTLSTORED] = ctlHeld_ff;
        statusWord[15-`CHACS_SW_HOSTSTORED] = hostHeld_ff;
        statusWord[7:0] = (hostHeld_ff && !ctlHeld_ff) ? hostCmdByte_ff : ctlBuf_ff[7:0];
    end
    always_ff @(posedge core_clk)
    begin
        if (fullReset)
        begin
            senseWord_ff <= '0;
            senseValid_ff <= 1'b0;
            ctlIrq_ff <= 1'b0;
            addrCheckIrq_ff <= 1'b0;
        end
        else
        begin
            senseValid_ff <= isSense;
            if (isSense)
                senseWord_ff <= ioCmd.word.modifier[`CHACS_MOD_BIT] ?
                                16'({2'h0, wordCnt_ff}) : statusWord;
            ctlIrq_ff <= (|setF) || hostIrq;
            addrCheckIrq_ff <= setF[`CHACS_SW_REJECT];
        end
    end

    // Mainframe status byte, bit 0 is the MSB position
    always_ff @(posedge core_clk)
    begin
        if (fullReset)
            hostStatus_ff <= '0;
        else
        begin
            hostStatus_ff <= '0;
            hostStatus_ff[7-`CHACS_SB_ATTN] <= state_ff == chacs_pkg::CHACS_WAITING;
            hostStatus_ff[7-`CHACS_SB_BUSY] <= hostHeld_ff || state_ff == chacs_pkg::CHACS_XFER;
            hostStatus_ff[7-`CHACS_SB_CE]   <= state_ff == chacs_pkg::CHACS_ENDING ||
                                                (hostCmdValid && hostNoop);
            hostStatus_ff[7-`CHACS_SB_DE]   <= state_ff == chacs_pkg::CHACS_ENDING ||
                                                ctrlDePending_ff || (hostCmdValid && hostNoop);
        end
    end
endmodule

// File: src/chacs_map.svh
// Overview of operation
// - Idle initialize-read buffers control word, raises attention
// - Read meets mainframe write: transfer until count zero
// - Overlapping initialize rejected, reject plus controller-stored
// - Init-read against held read/control rejected
// - Initialize-write mirrors initialize-read, directions swapped
// - Control function resets whole adapter, request latch
// - Status byte: attention 0, busy 3, ends 4,5
// - Attention while controller command awaits; busy when active
// - Channel end and device end timing rules
// - Status word bit layout, interrupting flags
// - Command reject causes, interrupts, sense-15 clear
// - Controller-stored sets on accept, clears at transfer-end
// - Mainframe-stored flag, suppressible interrupt, clearing
// - Halt on mainframe stop or disconnect
// - Data check on memory or bus-out parity
// - First-cycle parity resets if no mainframe command held, else steal retried; later parity ends transfer
// - Command parity fault ignores command, no data check
// - Protect violation ends operation, sets storage protect; checked only on steals writing controller storage
// - Transfer-end causes; blocks new initializes
// - End of table at count zero if requested
// - Bits 8-15 carry held mainframe command byte unless a controller command is stored
// - Unmodified sense returns status and low buffer
// - Modified sense returns 14-bit word count
// - Decode function codes, reject all others
`ifndef CHACS_MAP_SVH
`define CHACS_MAP_SVH
`define CHACS_FN_INIT_WR 3'h5
`define CHACS_FN_INIT_RD 3'h6
`define CHACS_FN_SENSE_DEV 3'h7
`define CHACS_FN_SENSE_INT 3'h3
`define CHACS_FN_CONTROL 3'h4
`define CHACS_SB_ATTN 0
`define CHACS_SB_BUSY 3
`define CHACS_SB_CE 4
`define CHACS_SB_DE 5
`define CHACS_SW_REJECT 0
`define CHACS_SW_CTLSTORED 1
`define CHACS_SW_HOSTSTORED 2
`define CHACS_SW_HALT 3
`define CHACS_SW_DCHECK 4
`define CHACS_SW_PROTECT 5
`define CHACS_SW_XEND 6
`define CHACS_SW_EOT 7
`define CHACS_MOD_BIT 7
`define CHACS_CLR_BIT 0
`define CHACS_HC_READ 2'h2
`define CHACS_HC_WRITE 2'h1
`define CHACS_HC_CTRL 2'h3
`define CHACS_HC_RDBK 4'hc
`define CHACS_WC_ZERO 14'h0000
`endif

// File: src/chacs_pkg.sv
package chacs_pkg;
    typedef struct packed {
        logic [4:0] area;
        logic [2:0] func;
        logic [7:0] modifier;
    } chacs_ctl_word_t;

    typedef struct packed {
        logic       valid;
        logic       parityOk;
        chacs_ctl_word_t word;
    } chacs_io_control_command_t;

    typedef enum logic [1:0] {
        CHACS_IDLE    = 2'b00,
        CHACS_WAITING = 2'b01,
        CHACS_XFER    = 2'b10,
        CHACS_ENDING  = 2'b11
    } chacs_state_t;

    typedef enum logic [1:0] {
        CHACS_DIR_NONE  = 2'b00,
        CHACS_DIR_TOCTL = 2'b01,
        CHACS_DIR_TOHOST = 2'b10
    } chacs_dir_t;
endpackage

// File: src/chacs_fifo.sv
`timescale 1ns/1ps
module chacs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count_ff != (AW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData  = mem[rdPtr_ff];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always_ff @(posedge core_clk)
    begin
        if (doWr)
            mem[wrPtr_ff] <= inData;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || flush)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (doWr)
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            if (doRd)
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            if (doWr && !doRd)
                count_ff <= count_ff + 1'b1;
            else if (doRd && !doWr)
                count_ff <= count_ff - 1'b1;
        end
    end
endmodule

// File: sim/chacs_adapter_sva.sv
`timescale 1ns/1ps
module chacs_adapter_sva #(
    parameter int WC_W       = 14,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Controller side
    input  wire chacs_pkg::chacs_io_control_command_t ioCmd,
    input  wire logic                   senseValid_ff,
    input  wire logic                   ctlIrq_ff,
    input  wire logic                   addrCheckIrq_ff,
    input  wire logic                   cycle_steal_request_latch_ff,
    input  wire logic                   csDirToCtl_ff,
    input  wire logic [15:0]            csWrData_ff,
    input  wire logic                   csDone,
    input  wire logic                   csParityErr,
    input  wire logic                   csProtectErr,
    // Mainframe side
    input  wire logic                   hostSelReset,
    input  wire logic                   hostMasterReset,
    input  wire logic [7:0]             hostStatus_ff
);
    logic       good;
    logic [2:0] fn;
    logic       stealErr;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    assign good     = ioCmd.valid && ioCmd.parityOk;
    assign fn       = ioCmd.word.func;
    assign stealErr = cycle_steal_request_latch_ff && csDone && csDirToCtl_ff && (csParityErr || csProtectErr);

    property p_bad_code;
        good && fn < 3'h3 |=> ctlIrq_ff && addrCheckIrq_ff;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code kept");
    property p_cmd_parity;
        ioCmd.valid && !ioCmd.parityOk |=> !addrCheckIrq_ff && !senseValid_ff;
    endproperty
    a_cmd_parity: assert property (p_cmd_parity) else $error("bad parity obeyed");
    property p_sense;
        good && fn == 3'h7 |=> senseValid_ff;
    endproperty
    a_sense: assert property (p_sense) else $error("sense not answered");
    property p_addr_irq;
        addrCheckIrq_ff |-> ctlIrq_ff;
    endproperty
    a_addr_irq: assert property (p_addr_irq) else $error("lone address check");
    property p_steal_hold;
        cycle_steal_request_latch_ff && !csDone && !(good && fn == 3'h4) && !hostSelReset && !hostMasterReset
            |=> cycle_steal_request_latch_ff && $stable(csDirToCtl_ff) && $stable(csWrData_ff);
    endproperty
    a_steal_hold: assert property (p_steal_hold) else $error("steal dropped");
    property p_ctl_reset;
        good && fn == 3'h4 |=> !cycle_steal_request_latch_ff && hostStatus_ff == 8'h00;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control no reset");
    property p_host_reset;
        (hostSelReset || hostMasterReset) [*3] |=> ##1 (!cycle_steal_request_latch_ff && hostStatus_ff == 8'h00);
    endproperty
    a_host_reset: assert property (p_host_reset) else $error("mainframe reset ignored");
    property p_err_irq;
        stealErr |=> ctlIrq_ff;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("fault no irq");
    property p_err_ends;
        stealErr |-> ##[1:12] (hostStatus_ff[3] && hostStatus_ff[2]);
    endproperty
    a_err_ends: assert property (p_err_ends) else $error("fault not ended");

    c_sense: cover property (good && fn == 3'h7);
    c_err: cover property (stealErr);
    c_reset: cover property (good && fn == 3'h4);
endmodule

bind chacs_adapter chacs_adapter_sva #(.WC_W(WC_W), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
    .core_clk, .rst, .ioCmd, .senseValid_ff, .ctlIrq_ff, .addrCheckIrq_ff, .cycle_steal_request_latch_ff, .csDirToCtl_ff,
    .csWrData_ff, .csDone, .csParityErr, .csProtectErr, .hostSelReset, .hostMasterReset, .hostStatus_ff
);

// File: sim/chacs_ctl_model.sv
`timescale 1ns/1ps
module chacs_ctl_model #(
    parameter int LAT = 2
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Steal request
    input  wire logic        cycle_steal_request_latch_ff,
    input  wire logic        csDirToCtl_ff,
    input  wire logic [15:0] csWrData_ff,
    // Scenario controls
    input  wire logic [15:0] rdWord,
    input  wire logic        errProt,
    input  wire logic        errPar,
    // Steal completion
    output logic             csDone,
    output logic [15:0]      csRdData,
    output logic             csParityErr,
    output logic             csProtectErr
);
    int          waitCnt;
    logic [15:0] got [$];

    // Slow memory, and read data that keeps changing outside an answer
    always @(posedge core_clk)
    begin
        csDone       <= 1'b0;
        csParityErr  <= 1'b0;
        csProtectErr <= 1'b0;
        csRdData     <= ~csRdData;
        if (rst)
        begin
            waitCnt  <= 0;
            csRdData <= 16'h0000;
        end
        else if (cycle_steal_request_latch_ff && !csDone && waitCnt < LAT)
            waitCnt <= waitCnt + 1;
        else if (cycle_steal_request_latch_ff && !csDone)
        begin
            waitCnt      <= 0;
            csDone       <= 1'b1;
            csParityErr  <= errPar;
            csProtectErr <= errProt;
            if (!csDirToCtl_ff)
                csRdData <= rdWord;
            else
                got.push_back(csWrData_ff);
        end
    end
endmodule

// File: sim/channel_adapter_command_status_tb_top.sv
`timescale 1ns/1ps
module channel_adapter_command_status_tb_top;
    logic                   core_clk, rst, senseValid_ff, ctlIrq_ff, addrCheckIrq_ff, cycle_steal_request_latch_ff;
    logic                   csDirToCtl_ff, csDone, csParityErr, csProtectErr, errProt, errPar;
    logic                   hostCmdValid, hostStop, hostSelReset, hostMasterReset, hostStatusAccept;
    logic                   hostWrValid, hostWrReady_ff;
    chacs_pkg::chacs_io_control_command_t ioCmd;
    logic [15:0]            senseWord_ff, csWrData_ff, csRdData, rdWord, hostWrData, lastSense;
    logic [7:0]             hostCmd, hostStatus_ff;
    logic [7:0]             expFlags [4] = '{8'h03, 8'h06, 8'h0a, 8'h12};
    int                     errCount = 0, nTests = 0, irqN = 0, addrN = 0, doneN = 0, senseN = 0;

    chacs_adapter dut (
        .core_clk, .rst, .ioCmd, .senseWord_ff, .senseValid_ff, .ctlIrq_ff, .addrCheckIrq_ff, .cycle_steal_request_latch_ff,
        .csDirToCtl_ff, .csWrData_ff, .csDone, .csRdData, .csParityErr, .csProtectErr, .csChain(1'b0),
        .hostCmdValid, .hostCmd, .hostNoop(1'b0), .hostStop, .hostDisconnect(1'b0), .hostSelReset,
        .hostMasterReset, .hostStatusAccept, .hostBusOutParityErr(1'b0), .hostWrValid, .hostWrData,
        .hostWrReady_ff, .hostRdValid_ff(), .hostRdData_ff(), .hostRdReady(1'b1), .hostStatus_ff
    );
    chacs_ctl_model ctl (
        .core_clk, .rst, .cycle_steal_request_latch_ff, .csDirToCtl_ff, .csWrData_ff, .rdWord, .errProt, .errPar, .csDone,
        .csRdData, .csParityErr, .csProtectErr
    );

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (ctlIrq_ff === 1'b1) irqN++;
        if (addrCheckIrq_ff === 1'b1) addrN++;
        if (csDone === 1'b1) doneN++;
        if (senseValid_ff === 1'b1)
        begin
            senseN++;
            lastSense = senseWord_ff;
        end
    end

    task automatic print_verdict();
        if (errCount == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n)
            @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        nTests++;
        if (ok !== 1'b1)
        begin
            errCount++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic cmd(input logic [2:0] f, input logic [7:0] m, input logic par);
        ioCmd = '{1'b1, par, '{5'h00, f, m}};
        tick(1);
        ioCmd.valid = 1'b0;
        tick(1);
    endtask
    task automatic sense(input logic [7:0] m, ef, input string s, input logic [7:0] el = 8'h00, lm = 8'h00);
        int n0;
        n0 = senseN;
        cmd(3'h7, m, 1'b1);
        for (int i = 0; i < 8 && senseN == n0; i++) tick(1);
        chk(senseN != n0 && lastSense[15:8] === ef && (lastSense[7:0] & lm) === el, s);
    endtask
    task automatic hcmd(input logic [7:0] c);
        hostCmd = c;
        hostCmdValid = 1'b1;
        tick(1);
        hostCmdValid = 1'b0;
        tick(1);
    endtask
    task automatic hwrite(input logic [15:0] d);
        hostWrData = d;
        hostWrValid = 1'b1;
        for (int i = 0; i < 50 && hostWrReady_ff !== 1'b1; i++) tick(1);
        chk(hostWrReady_ff === 1'b1, "host word refused");
        tick(1);
        hostWrValid = 1'b0;
        tick(1);
    endtask
    task automatic waitDone(input int n);
        for (int i = 0; i < 40 && doneN <= n; i++) tick(1);
        chk(doneN > n, "steal not answered");
    endtask
    task automatic accept();
        hostStatusAccept = 1'b1;
        tick(4);
        hostStatusAccept = 1'b0;
        tick(3);
        chk(hostStatus_ff === 8'h00, "status not released");
    endtask

    initial
    begin
        int n0;
        rst = 1'b1;
        ioCmd = '0;
        {hostCmdValid, hostStop, hostSelReset, hostMasterReset, hostStatusAccept, hostWrValid, errProt, errPar} = '0;
        hostCmd = 8'h00;
        hostWrData = 16'h0000;
        rdWord = 16'h0000;
        tick(2);
        rst = 1'b0;
        tick(2);
        chk(hostStatus_ff === 8'h00, "idle status");
        sense(8'h01, 8'h00, "idle flags");
        cmd(3'h6, 8'h00, 1'b0);
        chk(irqN == 0 && hostStatus_ff === 8'h00, "faulted command acted on");
        for (int f = 0; f < 3; f++)
        begin
            cmd(3'(f), 8'h00, 1'b1);
            chk(addrN == f + 1 && irqN == f + 1, "no reject interrupt");
            sense(8'h01, 8'h80, "reject flag");
            sense(8'h00, 8'h00, "reject not cleared");
        end
        for (int k = 0; k < 3; k++)
        begin
            cmd(3'h6, 8'h00, 1'b1);
            chk(hostStatus_ff === 8'h80, "attention");
            sense(8'h00, 8'h40, "command stored");
            cmd(3'h5, 8'h00, 1'b1);
            sense(8'h01, 8'hc0, "overlap reject");
            if (k == 0)
                cmd(3'h4, 8'h00, 1'b1);
            else
            begin
                {hostMasterReset, hostSelReset} = 2'(k);
                tick(5);
                {hostMasterReset, hostSelReset} = 2'b00;
            end
            tick(4);
            chk(hostStatus_ff === 8'h00, "not reset");
            sense(8'h00, 8'h00, "flags kept");
        end
        hcmd(8'h03);
        sense(8'h00, 8'h20, "control held", 8'h03, 8'hff);
        cmd(3'h6, 8'h00, 1'b1);
        sense(8'h01, 8'ha0, "read against control", 8'h03, 8'hff);
        chk(hostStatus_ff[2] === 1'b1, "no device end");
        sense(8'h00, 8'h00, "control not cleared");
        accept();
        for (int k = 0; k < 4; k++)
        begin
            ctl.got.delete();
            hcmd(8'h01);
            rdWord = (k == 0) ? 16'h4002 : 16'h0008;
            n0 = doneN;
            cmd(3'h6, 8'h00, 1'b1);
            waitDone(n0);
            if (k == 0)
            begin
                chk(hostStatus_ff[4] === 1'b1, "busy off in transfer");
                sense(8'h80, 8'h00, "loaded count", 8'h02, 8'hff);
            end
            errProt = (k == 1);
            errPar = (k == 2);
            hwrite(16'h1234);
            if (k == 0)
                hwrite(16'h5678);
            if (k == 3)
            begin
                waitDone(n0 + 1);
                hostStop = 1'b1;
            end
            for (int i = 0; i < 40 && hostStatus_ff[3] !== 1'b1; i++) tick(1);
            hostStop = 1'b0;
            chk(hostStatus_ff[3:2] === 2'b11, "no ending status");
            if (k == 0)
                chk(ctl.got.size() == 2 && ctl.got[0] === 16'h1234 && ctl.got[1] === 16'h5678, "data");
            sense(8'h01, expFlags[k], "ending flags");
            {errProt, errPar} = 2'b00;
            accept();
        end
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        errCount++;
        print_verdict();
    end
endmodule
